//--- srg_map.vh
// constants for the supervisor reset / watchdog guard block
`ifndef SRG_MAP_VH
`define SRG_MAP_VH
// ****************************************
// clock and timebase
// ****************************************
`define SRG_CLK_MHZ 250
// timebase tick period in ns (1 us tick)
`define SRG_TICK_NS 1000
`define SRG_TICK_CYC 250
`define SRG_TICK_W 8
// ****************************************
// timeouts in their own units
// ****************************************
// watchdog period 1.6 s, in ms
`define SRG_WDOG_MS 1600
// power-up reset timeout, nominal 200 ms (130..270)
`define SRG_PURST_MS 200
// self-timed write cycle, at most 10 ms
`define SRG_WRITE_MS 10
// supply threshold to reset delay, at most 5 us
`define SRG_RPD_US 5
// reset pin glitch reject, 100 ns or less ignored
`define SRG_GLITCH_NS 100
// serial input noise suppression, 200 ns
`define SRG_NOISE_NS 200
// counter width for tick-based timeouts
`define SRG_TMO_W 24
// ****************************************
// derived counts in cycles and ticks
// ****************************************
// last cycle of the 250-cycle tick divider
`define SRG_TICK_LAST 8'hF9
// 26 cycles: pulses of 25 cycles (100 ns) or less are dropped
`define SRG_GLITCH_CYC 5'h1A
// 50 cycles: anything shorter than 200 ns is dropped
`define SRG_NOISE_CYC 7'h32
// periods in 1 us ticks: 1600000, 200000 and 10000
`define SRG_WDOG_TICKS 24'h186A00
`define SRG_PURST_TICKS 24'h030D40
`define SRG_WRITE_TICKS 24'h002710
`endif

//--- srg_guard.v
// supervisor reset, watchdog and memory write guard
//
// How it works
// - watchdog times out after 1.6 s without any kick input edge
// - watchdog timeout starts reset condition, both reset outputs active
// - any kick edge clears watchdog count; host must kick faster
// - watchdog counter held at zero while reset condition is active
// - resets held until supply good, then power-up timeout of 200 ms
// - after timeout both open-drain reset pins are released
// - supply falling below threshold makes resets active at once
// - resets asserted within 5 us of supply crossing threshold
// - external drive of either reset pin starts a timed reset condition of 200 ms
// - manual reset is edge triggered on either reset pin
// - reset pin pulses of 100 ns or less are ignored
// - write-protect high refuses all memory programming
// - writes inhibited whenever supply is below threshold
// - no memory access or acknowledge while a reset is active
// - self-timed write from valid stop, at most 10 ms, bus disabled
// - noise pulses under 200 ns on clock and data suppressed
`timescale 1ns/100ps
`default_nettype none
`include "srg_map.vh"

module srg_guard #(
  // periods in 1 us ticks; benches shrink them to keep runs short
  parameter [`SRG_TMO_W-1:0] WDOG_TICKS = `SRG_WDOG_TICKS,
  parameter [`SRG_TMO_W-1:0] PURST_TICKS = `SRG_PURST_TICKS,
  parameter [`SRG_TMO_W-1:0] WRITE_TICKS = `SRG_WRITE_TICKS
) (
  input wire clk_in,
  input wire nrst_in,
  input wire supply_good_in,
  input wire watchdog_kick_input_in,
  input wire write_protect_in,
  input wire rst_hi_pin_in,
  input wire rst_lo_n_pin_in,
  input wire scl_in,
  input wire sda_in,
  input wire write_stop_in,
  output reg rst_hi_out,
  output reg rst_hi_oe_out,
  output reg rst_lo_n_out,
  output reg rst_lo_n_oe_out,
  output reg reset_active_out,
  output reg scl_clean_out,
  output reg sda_clean_out,
  output reg bus_enable_out,
  output reg write_allow_out,
  output reg write_busy_out,
  output reg wdog_timeout_out
);

  // ****************************************
  // derived cycle counts
  // ****************************************
  // filter lengths in cycles: the reset pin filter passes 26 cycles and
  // drops 25 (100 ns) or less; the serial filter passes 50 cycles and
  // drops anything shorter than 200 ns; the counts live in the map so
  // a clock up to 300 MHz only means new constants there
  localparam [4:0] GLITCH_CYC = `SRG_GLITCH_CYC;
  localparam [6:0] NOISE_CYC = `SRG_NOISE_CYC;
  localparam [`SRG_TICK_W-1:0] TICK_LAST = `SRG_TICK_LAST;

  // states of the reset controller, one-hot
  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_TIME = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  // ****************************************
  // timebase
  // ****************************************
  reg [`SRG_TICK_W-1:0] tick_cnt_q;
  reg tick_q;

  // one divider feeds every timeout, so they keep step
  // free-running 1 us enable pulse
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_cnt_q <= {`SRG_TICK_W{1'b0}};
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= {`SRG_TICK_W{1'b0}};
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // ****************************************
  // input filters
  // ****************************************
  // reset pins filtered; a level must persist past glitch time
  // our own drive passes the same filter, so it shows up here 26 cycles
  // late; the edge logic masks it with the output enables
  reg [4:0] hi_cnt_q;
  reg [4:0] lo_cnt_q;
  reg hi_filt_q;
  reg lo_n_filt_q;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hi_cnt_q <= 5'h00;
      lo_cnt_q <= 5'h00;
      // released levels, so no false edge follows reset
      hi_filt_q <= 1'b0;
      lo_n_filt_q <= 1'b1;
    end else begin
      // a long enough run of disagreeing samples flips the level
      if (rst_hi_pin_in == hi_filt_q) begin
        hi_cnt_q <= 5'h00;
      end else if (hi_cnt_q == GLITCH_CYC - 5'h01) begin
        hi_cnt_q <= 5'h00;
        hi_filt_q <= rst_hi_pin_in;
      end else begin
        hi_cnt_q <= hi_cnt_q + 5'h01;
      end
      if (rst_lo_n_pin_in == lo_n_filt_q) begin
        lo_cnt_q <= 5'h00;
      end else if (lo_cnt_q == GLITCH_CYC - 5'h01) begin
        lo_cnt_q <= 5'h00;
        lo_n_filt_q <= rst_lo_n_pin_in;
      end else begin
        lo_cnt_q <= lo_cnt_q + 5'h01;
      end
    end
  end

  // serial clock and data noise suppression, one filter per line
  wire [1:0] ser_raw;
  wire [1:0] ser_clean;
  assign ser_raw = {sda_in, scl_in};

  // both lines idle high, as the bus pull-ups leave them
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ser
      reg [6:0] cnt_q;
      reg lvl_q;
      // new level accepted only after it lasts the noise window
      always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          cnt_q <= 7'h00;
          lvl_q <= 1'b1;
        end else if (ser_raw[gi] == lvl_q) begin
          cnt_q <= 7'h00;
        end else if (cnt_q == NOISE_CYC - 7'h01) begin
          cnt_q <= 7'h00;
          lvl_q <= ser_raw[gi];
        end else begin
          cnt_q <= cnt_q + 7'h01;
        end
      end
      assign ser_clean[gi] = lvl_q;
    end
  endgenerate

  // ****************************************
  // edge detection
  // ****************************************
  reg hi_prev_q;
  reg lo_n_prev_q;
  reg kick_prev_q;
  wire manual_edge;
  wire kick_edge;

  // external drive seen only when we are not driving ourselves
  assign manual_edge = (hi_filt_q & ~hi_prev_q & ~rst_hi_oe_out) |
    (~lo_n_filt_q & lo_n_prev_q & ~rst_lo_n_oe_out);
  // kick taken raw: a synchronous input, so no filter lag on it
  assign kick_edge = watchdog_kick_input_in ^ kick_prev_q;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hi_prev_q <= 1'b0;
      lo_n_prev_q <= 1'b1;
      kick_prev_q <= 1'b0;
    end else begin
      hi_prev_q <= hi_filt_q;
      lo_n_prev_q <= lo_n_filt_q;
      kick_prev_q <= watchdog_kick_input_in;
    end
  end

  // ****************************************
  // reset controller
  // ****************************************
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [`SRG_TMO_W-1:0] rst_cnt_q;
  reg [`SRG_TMO_W-1:0] wd_cnt_q;
  wire wd_expire;
  wire in_reset;

  // timeout is reached on a tick once count reaches the period
  // expiry needs a tick past the period: no kick for longer than it
  assign wd_expire = (wd_cnt_q >= WDOG_TICKS) & tick_q;
  assign in_reset = ~state_q[2];

  // next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_HOLD: begin
        // held until supply reaches threshold
        if (supply_good_in) begin
          state_d = ST_TIME;
        end
      end
      ST_TIME: begin
        // supply loss while timing falls back to waiting
        if (!supply_good_in) begin
          state_d = ST_HOLD;
        end else if (tick_q && rst_cnt_q >= PURST_TICKS - 1'b1) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        // expiry and manual edge share the power-up timeout
        if (!supply_good_in) begin
          state_d = ST_HOLD;
        end else if (wd_expire || manual_edge) begin
          state_d = ST_TIME;
        end
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
  end

  // state and shared timeout counter
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_HOLD;
      rst_cnt_q <= {`SRG_TMO_W{1'b0}};
    end else begin
      state_q <= state_d;
      // edges are masked while we drive, so restarts come from run
      // a fresh edge restarts the full timeout
      if (state_d != ST_TIME || state_q != ST_TIME || manual_edge) begin
        rst_cnt_q <= {`SRG_TMO_W{1'b0}};
      end else if (tick_q) begin
        rst_cnt_q <= rst_cnt_q + 1'b1;
      end
    end
  end

  // watchdog counter in timebase ticks
  // cleared through state_d as well, so it never wraps past expiry
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wd_cnt_q <= {`SRG_TMO_W{1'b0}};
    end else if (in_reset || state_d != ST_RUN) begin
      wd_cnt_q <= {`SRG_TMO_W{1'b0}};
    end else if (kick_edge) begin
      wd_cnt_q <= {`SRG_TMO_W{1'b0}};
    end else if (tick_q) begin
      wd_cnt_q <= wd_cnt_q + 1'b1;
    end
  end

  // ****************************************
  // self-timed write cycle
  // ****************************************
  reg [`SRG_TMO_W-1:0] wr_cnt_q;
  reg wr_busy_q;
  wire wr_ok;

  // lockout by pin, supply and reset
  // a stop refused here is dropped, never kept for later
  assign wr_ok = ~write_protect_in & supply_good_in & ~in_reset;

  // counted write time; bus closed while busy
  // count parks at zero while idle so each write gets the full time
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_busy_q <= 1'b0;
      wr_cnt_q <= {`SRG_TMO_W{1'b0}};
    end else if (!wr_busy_q) begin
      wr_cnt_q <= {`SRG_TMO_W{1'b0}};
      if (write_stop_in && wr_ok) begin
        wr_busy_q <= 1'b1;
      end
    end else if (tick_q) begin
      if (wr_cnt_q >= WRITE_TICKS - 1'b1) begin
        wr_busy_q <= 1'b0;
      end else begin
        wr_cnt_q <= wr_cnt_q + 1'b1;
      end
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  // open-drain: drive active level only in reset, else release
  // value pins are constant; only the enables move, so the pull
  // resistors set the idle level once we let go
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_hi_out <= 1'b1;
      rst_hi_oe_out <= 1'b1;
      rst_lo_n_out <= 1'b0;
      rst_lo_n_oe_out <= 1'b1;
      reset_active_out <= 1'b1;
    end else begin
      rst_hi_out <= 1'b1;
      rst_lo_n_out <= 1'b0;
      // enables follow the next state, so a brownout shows one cycle on
      rst_hi_oe_out <= ~state_d[2];
      rst_lo_n_oe_out <= ~state_d[2];
      reset_active_out <= ~state_d[2];
    end
  end

  // filtered lines and bus, write and watchdog status
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_clean_out <= 1'b1;
      sda_clean_out <= 1'b1;
      bus_enable_out <= 1'b0;
      write_allow_out <= 1'b0;
      write_busy_out <= 1'b0;
      wdog_timeout_out <= 1'b0;
    end else begin
      scl_clean_out <= ser_clean[0];
      sda_clean_out <= ser_clean[1];
      // no access or ack in reset or write cycle
      bus_enable_out <= state_d[2] & ~wr_busy_q & supply_good_in;
      write_allow_out <= state_d[2] & ~wr_busy_q & ~write_protect_in &
        supply_good_in;
      write_busy_out <= wr_busy_q;
      // a pulse only when the expiry itself ends the run phase
      wdog_timeout_out <= wd_expire & state_q[2] & supply_good_in;
    end
  end

endmodule // srg_guard
`default_nettype wire

//--- srg_guard_checker.sv
// assertion checker bound to the guard's ports
`timescale 1ns/100ps
`default_nettype none
module srg_guard_checker (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic supply_good_in,
  input wire logic watchdog_kick_input_in,
  input wire logic write_protect_in,
  input wire logic write_stop_in,
  input wire logic rst_hi_oe_out,
  input wire logic rst_lo_n_oe_out,
  input wire logic reset_active_out,
  input wire logic bus_enable_out,
  input wire logic write_allow_out,
  input wire logic write_busy_out,
  input wire logic wdog_timeout_out
);
  // ****************************************
  // checks on the single clock
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  low_supply_a:
    assert property (!supply_good_in |=> rst_hi_oe_out && rst_lo_n_oe_out)
    else $error("reset pins idle on low supply");
  dog_resets_a:
    assert property (wdog_timeout_out |->
      ##[1:2] (rst_hi_oe_out && rst_lo_n_oe_out))
    else $error("no reset after watchdog expiry");
  dog_still_a:
    assert property (reset_active_out && $past(reset_active_out) |->
      !wdog_timeout_out)
    else $error("watchdog expired during reset");
  kick_clears_a:
    assert property ($changed(watchdog_kick_input_in) |=> !wdog_timeout_out)
    else $error("expiry right after a kick");
  reset_no_ack_a:
    assert property (reset_active_out |-> !bus_enable_out)
    else $error("bus enabled during reset");
  busy_no_ack_a:
    assert property (write_busy_out |-> !bus_enable_out)
    else $error("bus enabled during write");
  write_go_a:
    assert property (write_allow_out && write_stop_in && !write_busy_out
      |-> ##2 write_busy_out)
    else $error("write cycle did not start");
  wp_refuse_a:
    assert property (write_protect_in && write_stop_in |-> ##2
      !$rose(write_busy_out))
    else $error("write started while protected");
  low_lock_a:
    assert property (!supply_good_in && write_stop_in |-> ##2
      !$rose(write_busy_out))
    else $error("write started on low supply");
endmodule // srg_guard_checker
bind srg_guard srg_guard_checker chk_u (.clk_in, .nrst_in, .supply_good_in,
  .watchdog_kick_input_in, .write_protect_in, .write_stop_in, .rst_hi_oe_out,
  .rst_lo_n_oe_out, .reset_active_out, .bus_enable_out, .write_allow_out,
  .write_busy_out, .wdog_timeout_out);
`default_nettype wire

//--- srg_host_model.sv
// host side model: watchdog kicker and open-drain reset wiring
`timescale 1ns/100ps
`default_nettype none
module srg_host_model #(
  parameter int KICK_CYC = 1000
) (
  input wire logic clk_in,
  input wire logic kick_en_in,
  input wire logic hi_oe_in,
  input wire logic hi_val_in,
  input wire logic lo_oe_in,
  input wire logic lo_val_in,
  input wire logic [1:0] press_in,
  output var logic kick_out,
  output wire logic hi_pin_out,
  output wire logic lo_n_pin_out
);
  int cnt_q = 0;
  initial kick_out = 1'b0;
  // kick well inside the period; a stalled host simply stops toggling
  always @(negedge clk_in) begin
    cnt_q <= (cnt_q >= KICK_CYC) ? 0 : cnt_q + 1;
    if (kick_en_in && cnt_q == KICK_CYC) kick_out <= ~kick_out;
  end
  // pull-down on the high pin, pull-up on the low pin, press = button
  assign hi_pin_out = (hi_oe_in & hi_val_in) | press_in[0];
  assign lo_n_pin_out = ~((lo_oe_in & ~lo_val_in) | press_in[1]);
endmodule // srg_host_model
`default_nettype wire

//--- test_srg_guard.sv
// self-checking bench for the reset and watchdog guard
`timescale 1ns/100ps
`default_nettype none
module test_srg_guard;
  localparam int TK = 250;
  localparam int WD = 20;
  localparam int PU = 10;
  localparam int WR = 5;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic sup = 1'b0;
  logic wp = 1'b0;
  logic stop = 1'b0;
  logic ser = 1'b1;
  logic kick_en = 1'b1;
  logic [1:0] press = 2'h0;
  wire logic kick, hi_pin, lo_n_pin, hi_v, hi_oe, lo_v, lo_oe, ra;
  wire logic scl_c, sda_c, bus_en, busy, wa, dog;
  int error_cnt = 0;
  int comparisons = 0;
  int n;
  // ****************************************
  // clock, design and host
  // ****************************************
  always #2 clk_in = ~clk_in;
  // short counts keep the run small
  srg_guard #(.WDOG_TICKS(24'h14), .PURST_TICKS(24'h0A),
    .WRITE_TICKS(24'h05)) dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
    .supply_good_in(sup), .watchdog_kick_input_in(kick),
    .write_protect_in(wp), .rst_hi_pin_in(hi_pin), .rst_lo_n_pin_in(lo_n_pin),
    .scl_in(ser), .sda_in(ser), .write_stop_in(stop), .rst_hi_out(hi_v),
    .rst_hi_oe_out(hi_oe), .rst_lo_n_out(lo_v), .rst_lo_n_oe_out(lo_oe),
    .reset_active_out(ra), .scl_clean_out(scl_c), .sda_clean_out(sda_c),
    .bus_enable_out(bus_en), .write_allow_out(wa), .write_busy_out(busy),
    .wdog_timeout_out(dog));
  srg_host_model host_u (.clk_in(clk_in), .kick_en_in(kick_en),
    .hi_oe_in(hi_oe), .hi_val_in(hi_v), .lo_oe_in(lo_oe), .lo_val_in(lo_v),
    .press_in(press), .kick_out(kick), .hi_pin_out(hi_pin),
    .lo_n_pin_out(lo_n_pin));
  task automatic chk(input string s, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", s, e, g);
    end
  endtask
  task automatic chk_in(input string s, input int lo, input int hi);
    comparisons++;
    if (n < lo || n > hi) begin
      error_cnt++;
      $display("wrong value %s expected %0d..%0d seen %0d", s, lo, hi, n);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_in);
  endtask
  // bounded wait for the reset condition, a hang ends the run
  task automatic wait_ra(input logic v);
    for (n = 0; ra !== v; n++) begin
      cyc(1);
      if (n > 20000) begin
        chk("reset wait", v, ra);
        wrap_up();
      end
    end
  endtask
  task automatic pulse;
    stop = 1'b1;
    cyc(1);
    stop = 1'b0;
    cyc(1);
  endtask
  task automatic t_power;
    ser = 1'b0;
    cyc(20);
    chk("short dip", 1'b1, scl_c & sda_c);
    ser = 1'b1;
    cyc(60);
    ser = 1'b0;
    cyc(60);
    chk("long low", 1'b0, scl_c | sda_c);
    ser = 1'b1;
    cyc(60);
    chk("held", 1'b1, hi_pin & ~lo_n_pin);
    sup = 1'b1;
    wait_ra(1'b0);
    chk_in("power up", (PU - 1) * TK, (PU + 1) * TK);
    cyc(2);
    chk("released", 1'b0, hi_pin | ~lo_n_pin);
  endtask
  task automatic t_write;
    cyc(TK); // host holds off its first write after power-up
    wp = 1'b1;
    cyc(2);
    chk("wp allow", 1'b0, wa);
    pulse;
    chk("protected", 1'b0, busy);
    wp = 1'b0;
    cyc(2);
    chk("allow", 1'b1, wa);
    pulse;
    chk("bus off", 1'b0, bus_en | ~busy);
    for (n = 2; busy === 1'b1 && n < 3000; n++) cyc(1);
    if (busy !== 1'b0) begin
      chk("write end", 1'b0, busy);
      wrap_up();
    end
    chk_in("write time", (WR - 1) * TK, (WR + 1) * TK + 9);
    chk("bus back", 1'b1, bus_en);
    sup = 1'b0;
    cyc(2);
    chk("brownout", 1'b1, hi_oe & lo_oe);
    chk("no ack", 1'b0, bus_en);
    pulse;
    chk("low write", 1'b0, busy);
    sup = 1'b1;
    wait_ra(1'b0);
  endtask
  // either pin, a glitch first and then a real press
  task automatic t_manual;
    for (int i = 0; i < 2; i++) begin
      cyc(60); // both pin filters settle after our own release
      press[i] = 1'b1;
      cyc(20);
      press[i] = 1'b0;
      cyc(40);
      chk("glitch", 1'b0, ra);
      press[i] = 1'b1;
      wait_ra(1'b1);
      chk_in("press", 20, 40);
      press[i] = 1'b0;
      wait_ra(1'b0);
      chk_in("press end", (PU - 1) * TK, (PU + 1) * TK);
    end
  endtask
  task automatic t_wdog;
    cyc(2 * WD * TK);
    chk("kicked", 1'b0, ra);
    kick_en = 1'b0;
    wait_ra(1'b1);
    chk_in("watchdog", (WD - 1) * TK - 1000, (WD + 2) * TK);
    chk("dog pulse", 1'b1, dog);
    wait_ra(1'b0);
    cyc(12 * TK);
    chk("count held", 1'b0, ra);
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // main sequence, inputs move on the falling edge
  initial begin
    cyc(2);
    nrst_in = 1'b1;
    t_power;
    t_write;
    t_manual;
    t_wdog;
    wrap_up();
  end
endmodule // test_srg_guard
`default_nettype wire
